// ### common/cmr_cfg.svh
`ifndef CMR_CFG_SVH
`define CMR_CFG_SVH

// address map, 20-bit byte addresses
`define CMR_VEC_LO        20'h00000
`define CMR_VEC_HI        20'h0007f
`define CMR_TABLE_CALL_INSTRUCTION_LO      20'h00080
`define CMR_TABLE_CALL_INSTRUCTION_HI      20'h000bf
`define CMR_OPT_LO        20'h000c0
`define CMR_OPT_HI        20'h000c3
`define CMR_SID0_LO       20'h000c4
`define CMR_SID0_HI       20'h000cd
`define CMR_SID1_LO       20'h010c4
`define CMR_SID1_HI       20'h010cd
`define CMR_MIR_LO        20'hf8000
`define CMR_SFR2_LO       20'hf0000
`define CMR_SFR2_HI       20'hf07ff
`define CMR_RAM_HI        20'hffedf
`define CMR_RAM_LO_128    20'hffe60
`define CMR_RAM_LO_256    20'hffde0
`define CMR_RAM_LO_512    20'hffce0
`define CMR_GPR_LO        20'hffef8
`define CMR_GPR_HI        20'hffeff
`define CMR_SFR_LO        20'hfff00
`define CMR_FLASH_1K_HI   20'h003ff
`define CMR_FLASH_2K_HI   20'h007ff
`define CMR_FLASH_4K_HI   20'h00fff

// register port offsets (word index)
`define CMR_OFS_PSW       4'h0
`define CMR_OFS_SPL       4'h1
`define CMR_OFS_SPH       4'h2
`define CMR_OFS_PMC       4'h3
`define CMR_OFS_ES        4'h4
`define CMR_OFS_CS        4'h5
`define CMR_OFS_PC0       4'h6
`define CMR_OFS_PC1       4'h7
`define CMR_OFS_PC2       4'h8
`define CMR_OFS_GPR0      4'h9
`define CMR_OFS_PSIZE     4'hd

// reset values
`define CMR_PSW_RST       8'h06
`define CMR_ES_RST        4'hf
`define CMR_CS_RST        4'h0
`define CMR_PMC_RST       2'h0

// status word bit positions
`define CMR_PSW_IE        7
`define CMR_PSW_Z         6
`define CMR_PSW_RBS1      5
`define CMR_PSW_AC        4
`define CMR_PSW_RBS0      3
`define CMR_PSW_IN_SERVICE_LEVEL_HIGH      2
`define CMR_PSW_IN_SERVICE_LEVEL_LOW      1
`define CMR_PSW_CY        0

`endif

// ### common/cmr_pkg.sv
package cmr_pkg;

  // decoded area of a 20-bit address
  typedef enum logic [10:0] {
    CMR_AREA_NONE  = 11'b000_0000_0001,
    CMR_AREA_VEC   = 11'b000_0000_0010,
    CMR_AREA_TABLE_CALL_INSTRUCTION = 11'b000_0000_0100,
    CMR_AREA_OPT   = 11'b000_0000_1000,
    CMR_AREA_SID   = 11'b000_0001_0000,
    CMR_AREA_CODE  = 11'b000_0010_0000,
    CMR_AREA_MIR   = 11'b000_0100_0000,
    CMR_AREA_SFR2  = 11'b000_1000_0000,
    CMR_AREA_RAM   = 11'b001_0000_0000,
    CMR_AREA_GPR   = 11'b010_0000_0000,
    CMR_AREA_SFR   = 11'b100_0000_0000
  } cmr_area_e;

  // core access request
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [19:0] addr;
  } cmr_acc_s;

  // access decode answer
  typedef struct packed {
    cmr_area_e   area;
    logic        allowed;
    logic        ext_byte;
    logic [19:0] phys;
  } cmr_dec_s;

  // sequencer commands
  typedef struct packed {
    logic        pc_step;
    logic [2:0]  pc_len;
    logic        pc_load;
    logic [19:0] pc_target;
    logic        vec_load;
    logic [15:0] vec_data;
    logic        sp_push;
    logic        sp_pop;
    logic        psw_push;
    logic        psw_pop;
    logic [7:0]  psw_pop_data;
    logic        di_op;
    logic        ei_op;
    logic        int_ack;
    logic        flag_upd;
    logic [16:0] alu_res;
    logic [7:0]  alu_a;
    logic [7:0]  alu_b;
    logic        alu_sub;
    logic        cy_upd;
    logic        cy_val;
    logic        gpr_we;
    logic [2:0]  gpr_sel;
    logic [7:0]  gpr_wdata;
  } cmr_cmd_s;

  // maskable request presented to the core
  typedef struct packed {
    logic       req;
    logic       masked;
    logic [1:0] prio;
  } cmr_irq_s;

  typedef struct packed {
    logic [7:0]  status_flags_word;
    logic [15:0] sp;
    logic [19:0] pc;
    logic [1:0]  processor_mode_control;
    logic [3:0]  es;
    logic [3:0]  cs;
    logic [7:0]  rdata;
    logic [63:0] gpr;
  } cmr_state_s;

endpackage : cmr_pkg

// ### src/cmr_core_regs.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "cmr_cfg.svh"
module cmr_core_regs (
  input  wire logic            i_clock,
  input  wire logic            i_nrst,
  input  wire cmr_pkg::cmr_acc_s i_acc,
  output logic                 o_acc_ok,
  output cmr_pkg::cmr_area_e   o_acc_area,
  output logic                 o_acc_ext_byte,
  output logic [19:0]          o_acc_phys,
  output logic                 o_sp_in_ram,
  input  wire cmr_pkg::cmr_cmd_s i_cmd,
  input  wire cmr_pkg::cmr_irq_s i_irq,
  output logic                 o_irq_take,
  output logic [7:0]           o_psw_push_data,
  output logic [19:0]          o_stack_addr,
  output logic [19:0]          o_pc,
  output logic [15:0]          o_sp,
  output logic [7:0]           o_psw,
  output logic [3:0]           o_es,
  output logic [3:0]           o_cs,
  output logic [15:0]          o_accumulator_pair,
  input  wire logic [3:0]      i_reg_addr,
  input  wire logic [7:0]      i_reg_wdata,
  input  wire logic            i_reg_wr,
  input  wire logic            i_reg_rd,
  output logic [7:0]           o_reg_rdata,
  input  wire logic [1:0]      i_prod_size
);
  import cmr_pkg::*;

  cmr_state_s st_r;
  cmr_state_s st_nxt;
  cmr_dec_s   dec;
  logic [19:0] ram_lo;
  logic [19:0] mir_hi;
  logic [19:0] flash_hi;
  logic        vec_pend_r;
  logic [8:0]  nib;
  logic [7:0]  gpr_b [8];

  // product-size ram base and mode-selected flash top
  always_comb begin
    case (i_prod_size)
      2'h1:    ram_lo = `CMR_RAM_LO_256;
      2'h2:    ram_lo = `CMR_RAM_LO_512;
      default: ram_lo = `CMR_RAM_LO_128;
    endcase
    case (st_r.processor_mode_control)
      2'h1:    flash_hi = `CMR_FLASH_2K_HI;
      2'h2:    flash_hi = `CMR_FLASH_4K_HI;
      default: flash_hi = `CMR_FLASH_1K_HI;
    endcase
    mir_hi = `CMR_MIR_LO | flash_hi;
  end

  // address area decode and access permission
  always_comb begin
    dec.area     = CMR_AREA_NONE;
    dec.allowed  = 1'b0;
    dec.ext_byte = 1'b0;
    dec.phys     = i_acc.addr;
    if (i_acc.addr <= `CMR_VEC_HI) begin
      dec.area    = CMR_AREA_VEC;
      dec.allowed = !i_acc.write;
    end else if (i_acc.addr <= `CMR_TABLE_CALL_INSTRUCTION_HI) begin
      dec.area    = CMR_AREA_TABLE_CALL_INSTRUCTION;
      dec.allowed = !i_acc.write && !i_acc.fetch;
    end else if (i_acc.addr <= `CMR_OPT_HI) begin
      dec.area    = CMR_AREA_OPT;
      dec.allowed = !i_acc.write && !i_acc.fetch;
    end else if (i_acc.addr <= `CMR_SID0_HI) begin
      dec.area    = CMR_AREA_SID;
      dec.allowed = 1'b0;
    end else if (i_acc.addr >= `CMR_SID1_LO && i_acc.addr <= `CMR_SID1_HI) begin
      dec.area    = CMR_AREA_SID;
      dec.allowed = 1'b0;
    end else if (i_acc.addr <= flash_hi) begin
      dec.area    = CMR_AREA_CODE;
      dec.allowed = !i_acc.write;
    end else if (i_acc.addr >= `CMR_SFR2_LO && i_acc.addr <= `CMR_SFR2_HI) begin
      dec.area     = CMR_AREA_SFR2;
      dec.allowed  = !i_acc.fetch;
      dec.ext_byte = 1'b1;
    end else if (i_acc.addr >= `CMR_MIR_LO && i_acc.addr <= mir_hi) begin
      dec.area    = CMR_AREA_MIR;
      dec.allowed = !i_acc.write && !i_acc.fetch;
      dec.phys    = i_acc.addr & flash_hi;
    end else if (i_acc.addr >= ram_lo && i_acc.addr <= `CMR_RAM_HI) begin
      dec.area    = CMR_AREA_RAM;
      dec.allowed = 1'b1;
    end else if (i_acc.addr >= `CMR_GPR_LO && i_acc.addr <= `CMR_GPR_HI) begin
      dec.area    = CMR_AREA_GPR;
      dec.allowed = !i_acc.fetch;
    end else if (i_acc.addr >= `CMR_SFR_LO) begin
      dec.area    = CMR_AREA_SFR;
      dec.allowed = !i_acc.fetch;
    end
  end

  assign o_acc_ok       = i_acc.valid && dec.allowed;
  assign o_acc_area     = dec.area;
  assign o_acc_ext_byte = dec.ext_byte;
  assign o_acc_phys     = dec.phys;

  // stack window check against ram only, never the register bank
  assign o_sp_in_ram = ({4'hf, st_r.sp} >= ram_lo) && ({4'hf, st_r.sp} <= `CMR_RAM_HI);

  // maskable acceptance: enable, mask, level (lower value is higher priority)
  always_comb begin
    o_irq_take = 1'b0;
    if (st_r.status_flags_word[`CMR_PSW_IE] && i_irq.req && !i_irq.masked) begin
      if (i_irq.prio < {st_r.status_flags_word[`CMR_PSW_IN_SERVICE_LEVEL_HIGH], st_r.status_flags_word[`CMR_PSW_IN_SERVICE_LEVEL_LOW]}) begin
        o_irq_take = 1'b1;
      end
    end
  end

  // nibble sum or difference for the auxiliary carry
  assign nib = i_cmd.alu_sub ? {5'h00, i_cmd.alu_a[3:0]} - {5'h00, i_cmd.alu_b[3:0]}
                             : {5'h00, i_cmd.alu_a[3:0]} + {5'h00, i_cmd.alu_b[3:0]};

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    // counter: vector load after reset, branch load, else step
    if (vec_pend_r && i_cmd.vec_load) begin
      st_nxt.pc = {4'h0, i_cmd.vec_data};
    end else if (i_cmd.pc_load) begin
      st_nxt.pc = i_cmd.pc_target;
    end else if (i_cmd.pc_step) begin
      st_nxt.pc = st_r.pc + {17'h00000, i_cmd.pc_len};
    end
    // stack pointer: pre-decrement on write, post-increment on read
    if (i_cmd.sp_push || i_cmd.psw_push || i_cmd.int_ack) begin
      st_nxt.sp = st_r.sp - 16'h0001;
    end else if (i_cmd.sp_pop || i_cmd.psw_pop) begin
      st_nxt.sp = st_r.sp + 16'h0001;
    end
    // flags from the alu result
    if (i_cmd.flag_upd) begin
      st_nxt.status_flags_word[`CMR_PSW_Z]  = (i_cmd.alu_res[15:0] == 16'h0000);
      st_nxt.status_flags_word[`CMR_PSW_AC] = nib[4];
    end
    if (i_cmd.cy_upd) begin
      st_nxt.status_flags_word[`CMR_PSW_CY] = i_cmd.cy_val;
    end else if (i_cmd.flag_upd) begin
      st_nxt.status_flags_word[`CMR_PSW_CY] = i_cmd.alu_res[16];
    end
    // status restore, then enable changes
    if (i_cmd.psw_pop) begin
      st_nxt.status_flags_word = i_cmd.psw_pop_data;
    end
    if (i_cmd.int_ack || i_cmd.di_op) begin
      st_nxt.status_flags_word[`CMR_PSW_IE] = 1'b0;
    end else if (i_cmd.ei_op) begin
      st_nxt.status_flags_word[`CMR_PSW_IE] = 1'b1;
    end
    // register bank write from the core
    if (i_cmd.gpr_we) begin
      st_nxt.gpr[{i_cmd.gpr_sel, 3'h0} +: 8] = i_cmd.gpr_wdata;
    end
    // software register port writes take last word
    if (i_reg_wr) begin
      if (i_reg_addr == `CMR_OFS_PSW) begin
        st_nxt.status_flags_word = i_reg_wdata;
      end else if (i_reg_addr == `CMR_OFS_SPL) begin
        st_nxt.sp[7:0] = i_reg_wdata;
      end else if (i_reg_addr == `CMR_OFS_SPH) begin
        st_nxt.sp[15:8] = i_reg_wdata;
      end else if (i_reg_addr == `CMR_OFS_PMC) begin
        st_nxt.processor_mode_control = i_reg_wdata[1:0];
      end else if (i_reg_addr == `CMR_OFS_ES) begin
        st_nxt.es = i_reg_wdata[3:0];
      end else if (i_reg_addr == `CMR_OFS_CS) begin
        st_nxt.cs = i_reg_wdata[3:0];
      end
    end
    // read data, valid in the following cycle
    st_nxt.rdata = 8'h00;
    if (i_reg_rd) begin
      if (i_reg_addr == `CMR_OFS_PSW) begin
        st_nxt.rdata = st_r.status_flags_word;
      end else if (i_reg_addr == `CMR_OFS_SPL) begin
        st_nxt.rdata = st_r.sp[7:0];
      end else if (i_reg_addr == `CMR_OFS_SPH) begin
        st_nxt.rdata = st_r.sp[15:8];
      end else if (i_reg_addr == `CMR_OFS_PMC) begin
        st_nxt.rdata = {6'h00, st_r.processor_mode_control};
      end else if (i_reg_addr == `CMR_OFS_ES) begin
        st_nxt.rdata = {4'h0, st_r.es};
      end else if (i_reg_addr == `CMR_OFS_CS) begin
        st_nxt.rdata = {4'h0, st_r.cs};
      end else if (i_reg_addr == `CMR_OFS_PC0) begin
        st_nxt.rdata = st_r.pc[7:0];
      end else if (i_reg_addr == `CMR_OFS_PC1) begin
        st_nxt.rdata = st_r.pc[15:8];
      end else if (i_reg_addr == `CMR_OFS_PC2) begin
        st_nxt.rdata = {4'h0, st_r.pc[19:16]};
      end else if (i_reg_addr >= `CMR_OFS_GPR0 && i_reg_addr < `CMR_OFS_PSIZE) begin
        st_nxt.rdata = gpr_b[3'(i_reg_addr - `CMR_OFS_GPR0) + 3'h1]; // offset 9 is bank byte 1
      end
    end
  end

  // per-register byte view of the bank
  for (genvar g = 0; g < 8; g++) begin : g_gpr
    assign gpr_b[g] = st_r.gpr[g*8 +: 8];
  end

  // state register; stack pointer left at zero only as a lint-safe constant
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r.status_flags_word   <= `CMR_PSW_RST;
      st_r.sp    <= 16'h0000;
      st_r.pc    <= 20'h00000;
      st_r.processor_mode_control   <= `CMR_PMC_RST;
      st_r.es    <= `CMR_ES_RST;
      st_r.cs    <= `CMR_CS_RST;
      st_r.rdata <= 8'h00;
      st_r.gpr   <= 64'h0;
      vec_pend_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      if (i_cmd.vec_load) begin
        vec_pend_r <= 1'b0;
      end
    end
  end

  // outputs
  assign o_psw_push_data    = st_r.status_flags_word;
  assign o_stack_addr       = {4'hf, st_r.sp - 16'h0001};
  assign o_pc               = st_r.pc;
  assign o_sp               = st_r.sp;
  assign o_psw              = st_r.status_flags_word;
  assign o_es               = st_r.es;
  assign o_cs               = st_r.cs;
  assign o_accumulator_pair = {gpr_b[1], gpr_b[0]};
  assign o_reg_rdata        = st_r.rdata;

endmodule : cmr_core_regs

// ### test/cmr_core_regs_asserts.sv
`timescale 1ns/10ps
`include "cmr_cfg.svh"
module cmr_core_regs_asserts (
  input wire logic               i_clock,
  input wire logic               i_nrst,
  input wire cmr_pkg::cmr_acc_s  i_acc,
  input wire logic               o_acc_ok,
  input wire cmr_pkg::cmr_area_e o_acc_area,
  input wire logic               o_acc_ext_byte,
  input wire cmr_pkg::cmr_cmd_s  i_cmd,
  input wire cmr_pkg::cmr_irq_s  i_irq,
  input wire logic               o_irq_take,
  input wire logic [19:0]        o_stack_addr,
  input wire logic [19:0]        o_pc,
  input wire logic [15:0]        o_sp,
  input wire logic [7:0]         o_psw,
  input wire logic               i_reg_wr
);
  import cmr_pkg::*;
  // one clock domain, reset gates all checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  AST_IE_GATE: assert property (o_irq_take |-> o_psw[7] && i_irq.req && !i_irq.masked)
    else $error("request taken while disabled or masked");
  AST_PRIO_GATE: assert property (o_irq_take |-> i_irq.prio < o_psw[2:1])
    else $error("request taken below in-service level");
  AST_TAKE: assert property (o_psw[7] && i_irq.req && !i_irq.masked &&
    (i_irq.prio < o_psw[2:1]) |-> o_irq_take) else $error("permitted request not taken");
  AST_PC_STEP: assert property (i_cmd.pc_step && !i_cmd.pc_load && !i_cmd.vec_load |=>
    o_pc == $past(o_pc) + 20'($past(i_cmd.pc_len))) else $error("counter step wrong");
  AST_PC_LOAD: assert property (i_cmd.pc_load && !i_cmd.pc_step && !i_cmd.vec_load |=>
    o_pc == $past(i_cmd.pc_target)) else $error("counter load wrong");
  AST_SP_DEC: assert property (i_cmd.sp_push && !i_cmd.psw_push && !i_cmd.int_ack &&
    !i_reg_wr |=> o_sp == $past(o_sp) - 16'h1) else $error("push did not decrement");
  AST_SP_INC: assert property (i_cmd.sp_pop && !i_cmd.sp_push && !i_cmd.psw_push &&
    !i_cmd.int_ack && !i_cmd.psw_pop && !i_reg_wr |=> o_sp == $past(o_sp) + 16'h1)
    else $error("pop did not increment");
  AST_STK_ADDR: assert property (o_stack_addr == {4'hf, o_sp - 16'h1})
    else $error("push address wrong");
  AST_MIR_RO: assert property (i_acc.valid && (i_acc.fetch || i_acc.write) &&
    o_acc_area == CMR_AREA_MIR |-> !o_acc_ok) else $error("mirror fetch or write allowed");
  AST_GPR_NOFETCH: assert property (i_acc.valid && i_acc.fetch &&
    o_acc_area == CMR_AREA_GPR |-> !o_acc_ok) else $error("register bank fetch allowed");
  AST_EXT_BYTE: assert property (i_acc.valid |->
    o_acc_ext_byte == (o_acc_area == CMR_AREA_SFR2)) else $error("extra byte flag wrong");
  AST_IE_CLR: assert property ((i_cmd.int_ack || i_cmd.di_op) && !i_reg_wr &&
    !i_cmd.psw_pop |=> !o_psw[7]) else $error("enable flag not cleared");
  AST_ZERO: assert property (i_cmd.flag_upd && !i_reg_wr && !i_cmd.psw_pop |=>
    o_psw[6] == ($past(i_cmd.alu_res[15:0]) == 16'h0)) else $error("zero flag wrong");
endmodule : cmr_core_regs_asserts

bind cmr_core_regs cmr_core_regs_asserts u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_acc(i_acc), .o_acc_ok(o_acc_ok), .o_acc_area(o_acc_area),
  .o_acc_ext_byte(o_acc_ext_byte), .i_cmd(i_cmd), .i_irq(i_irq), .o_irq_take(o_irq_take),
  .o_stack_addr(o_stack_addr), .o_pc(o_pc), .o_sp(o_sp), .o_psw(o_psw), .i_reg_wr(i_reg_wr));

// ### test/cmr_core_regs_tb.sv
`timescale 1ns/10ps
`include "cmr_cfg.svh"
module cmr_core_regs_tb;
  import cmr_pkg::*;
  logic        i_clock, i_nrst, i_reg_wr, i_reg_rd, o_acc_ok, o_acc_ext_byte;
  logic        o_sp_in_ram, o_irq_take;
  logic [3:0]  i_reg_addr, o_es, o_cs;
  logic [7:0]  i_reg_wdata, o_psw_push_data, o_psw, o_reg_rdata, rv;
  logic [1:0]  i_prod_size;
  logic [19:0] o_acc_phys, o_stack_addr, o_pc, epc;
  logic [15:0] o_sp, o_accumulator_pair, rnd, esp;
  cmr_acc_s    i_acc;
  cmr_cmd_s    i_cmd, c;
  cmr_irq_s    i_irq;
  cmr_area_e   o_acc_area;
  int          fails, n_compared;
  localparam logic [19:0] TA [17] = '{20'h00090, 20'h000c1, 20'h000cd, 20'h010c4, 20'h00200,
    20'hf8010, 20'hf8400, 20'hf8400, 20'hf0100, 20'hffe60, 20'hffde0, 20'hffde0, 20'hffce0,
    20'hffef9, 20'hfff05, 20'h00004, 20'hf8c00};
  localparam logic [3:0] TS [17] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0,
    4'h0, 4'h0, 4'h4, 4'h8, 4'h0, 4'h0, 4'h0, 4'h2};
  localparam cmr_area_e TR [17] = '{CMR_AREA_TABLE_CALL_INSTRUCTION, CMR_AREA_OPT, CMR_AREA_SID, CMR_AREA_SID,
    CMR_AREA_CODE, CMR_AREA_MIR, CMR_AREA_NONE, CMR_AREA_MIR, CMR_AREA_SFR2, CMR_AREA_RAM,
    CMR_AREA_NONE, CMR_AREA_RAM, CMR_AREA_RAM, CMR_AREA_GPR, CMR_AREA_SFR, CMR_AREA_VEC,
    CMR_AREA_MIR};
  localparam logic [15:0] SPV [6] = '{16'hfe60, 16'hfe5f, 16'hfde0, 16'hfcdf, 16'hfef9, 16'hfedf};

  cmr_core_regs dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_acc(i_acc), .o_acc_ok(o_acc_ok),
    .o_acc_area(o_acc_area), .o_acc_ext_byte(o_acc_ext_byte), .o_acc_phys(o_acc_phys),
    .o_sp_in_ram(o_sp_in_ram), .i_cmd(i_cmd), .i_irq(i_irq), .o_irq_take(o_irq_take),
    .o_psw_push_data(o_psw_push_data), .o_stack_addr(o_stack_addr), .o_pc(o_pc),
    .o_sp(o_sp), .o_psw(o_psw), .o_es(o_es), .o_cs(o_cs),
    .o_accumulator_pair(o_accumulator_pair), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_prod_size(i_prod_size));

  // 40 mhz clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // ram window for a product size
  function automatic logic in_ram(input logic [19:0] a, input logic [1:0] s);
    logic [19:0] lo;
    lo = (s == 2'h2) ? `CMR_RAM_LO_512 : (s == 2'h1) ? `CMR_RAM_LO_256 : `CMR_RAM_LO_128;
    return a >= lo && a <= `CMR_RAM_HI;
  endfunction : in_ram

  // k: 0 read, 1 write, 2 fetch
  function automatic logic exp_ok(input cmr_area_e a, input int k);
    case (a)
      CMR_AREA_RAM: return 1'b1;
      CMR_AREA_VEC, CMR_AREA_CODE: return k != 1;
      CMR_AREA_TABLE_CALL_INSTRUCTION, CMR_AREA_OPT, CMR_AREA_MIR: return k == 0;
      CMR_AREA_SFR2, CMR_AREA_SFR, CMR_AREA_GPR: return k != 2;
      default: return 1'b0;
    endcase
  endfunction : exp_ok

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask : rd

  task automatic cmdp(input cmr_cmd_s x);
    @(posedge i_clock);
    i_cmd <= x;
    @(posedge i_clock);
    i_cmd <= '0;
    #1;
  endtask : cmdp

  // watchdog
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    close_out();
  end

  // main sequence
  initial begin
    {i_nrst, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_prod_size} = '0;
    i_acc = '0;
    i_cmd = '0;
    i_irq = '0;
    fails = 0;
    n_compared = 0;
    rnd = 16'h0029;
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    #1;
    chk(o_psw, `CMR_PSW_RST);
    chk({o_es, o_cs}, {`CMR_ES_RST, `CMR_CS_RST});
    rd(`CMR_OFS_PSW, rv);
    chk(rv, 8'h06);
    wr(4'he, 8'h5a);
    rd(4'he, rv);
    chk(rv, 8'h00);
    $display("test reset done");
    // vector load, steps, branches
    rnd = lfsr(rnd);
    c = '0;
    c.vec_load = 1'b1;
    c.vec_data = rnd;
    cmdp(c);
    chk(o_pc, {4'h0, rnd});
    c.vec_data = ~rnd;
    cmdp(c);
    chk(o_pc, {4'h0, rnd});
    epc = {4'h0, rnd};
    for (int k = 0; k < 14; k++) begin
      rnd = lfsr(rnd);
      c = '0;
      if (k == 12) rnd = 16'hfffe;
      if (rnd[0] && k != 13) begin
        c.pc_load = 1'b1;
        c.pc_target = {rnd[3:0], rnd};
        epc = c.pc_target;
      end else begin
        c.pc_step = 1'b1;
        c.pc_len = 3'(rnd[2:1]) + 3'h1;
        epc = epc + 20'(c.pc_len);
      end
      cmdp(c);
      chk(o_pc, epc);
    end
    rd(`CMR_OFS_PC0, rv);
    chk(rv, epc[7:0]);
    rd(`CMR_OFS_PC1, rv);
    chk(rv, epc[15:8]);
    rd(`CMR_OFS_PC2, rv);
    chk(rv, {4'h0, epc[19:16]});
    $display("test counter done");
    // stack pointer load, push, pop, ram window
    esp = {8'hfe, rnd[7:0]};
    wr(`CMR_OFS_SPL, esp[7:0]);
    wr(`CMR_OFS_SPH, esp[15:8]);
    chk(o_sp, esp);
    rd(`CMR_OFS_SPL, rv);
    chk(rv, esp[7:0]);
    chk(o_stack_addr, {4'hf, esp - 16'h1});
    c = '0;
    c.sp_push = 1'b1;
    cmdp(c);
    chk(o_sp, esp - 16'h1);
    c = '0;
    c.sp_pop = 1'b1;
    cmdp(c);
    cmdp(c);
    chk(o_sp, esp + 16'h1);
    for (int k = 0; k < 18; k++) begin
      i_prod_size <= 2'(k / 6);
      wr(`CMR_OFS_SPL, SPV[k % 6][7:0]);
      wr(`CMR_OFS_SPH, SPV[k % 6][15:8]);
      chk(o_sp_in_ram, in_ram({4'hf, SPV[k % 6]}, 2'(k / 6)));
    end
    $display("test stack done");
    // status word push, pop, enable control
    rnd = lfsr(rnd);
    wr(`CMR_OFS_PSW, rnd[7:0]);
    chk(o_psw_push_data, rnd[7:0]);
    c = '0;
    c.psw_pop = 1'b1;
    c.psw_pop_data = rnd[15:8];
    cmdp(c);
    chk(o_psw, rnd[15:8]);
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.ei_op = k[0];
      c.di_op = (k == 2);
      c.int_ack = (k == 0);
      cmdp(c);
      chk(o_psw[7], k[0]);
    end
    $display("test status done");
    // flag updates with random operands
    for (int k = 0; k < 10; k++) begin
      rnd = lfsr(rnd);
      c = '0;
      c.flag_upd = 1'b1;
      c.alu_a = rnd[7:0];
      c.alu_b = rnd[15:8];
      c.alu_sub = rnd[3];
      c.alu_res = {rnd[2], rnd[1] ? 16'h0 : rnd};
      c.cy_upd = rnd[5];
      c.cy_val = rnd[6];
      cmdp(c);
      chk(o_psw[6], c.alu_res[15:0] == 16'h0);
      chk(o_psw[4], c.alu_sub ? (c.alu_a[3:0] < c.alu_b[3:0]) :
        ({1'b0, c.alu_a[3:0]} + c.alu_b[3:0] > 5'h0f));
      chk(o_psw[0], c.cy_upd ? c.cy_val : c.alu_res[16]);
    end
    $display("test flags done");
    // every enable, level, priority, mask and request combination
    for (int q = 0; q < 8; q++) begin
      wr(`CMR_OFS_PSW, {q[2], 4'h0, q[1:0], 1'b0});
      for (int j = 0; j < 16; j++) begin
        @(posedge i_clock);
        i_irq <= {j[3], j[2], j[1:0]};
        #1;
        chk(o_irq_take, q[2] && j[3] && !j[2] && (j[1:0] < q[1:0]));
      end
    end
    $display("test interrupt done");
    // address decode table with read, write and fetch
    for (int e = 0; e < 17; e++) begin
      i_prod_size <= TS[e][3:2];
      wr(`CMR_OFS_PMC, {6'h0, TS[e][1:0]});
      for (int k = 0; k < 3; k++) begin
        @(posedge i_clock);
        i_acc <= {1'b1, k == 2, k == 1, TA[e]};
        #1;
        chk(o_acc_area, TR[e]);
        chk(o_acc_ok, exp_ok(TR[e], k));
        chk(o_acc_ext_byte, TR[e] == CMR_AREA_SFR2);
        if (TR[e] == CMR_AREA_MIR) chk(o_acc_phys, TA[e] - `CMR_MIR_LO);
      end
    end
    // an idle request is never allowed
    @(posedge i_clock);
    i_acc <= {1'b0, 1'b0, 1'b0, 20'hffe60};
    #1;
    chk(o_acc_ok, 1'b0);
    $display("test decode done");
    // register bank pair
    rnd = lfsr(rnd);
    c = '0;
    c.gpr_we = 1'b1;
    c.gpr_wdata = rnd[7:0];
    cmdp(c);
    c.gpr_sel = 3'h1;
    c.gpr_wdata = rnd[15:8];
    cmdp(c);
    chk(o_accumulator_pair, rnd);
    rd(`CMR_OFS_GPR0, rv);
    chk(rv, rnd[15:8]);
    $display("test bank done");
    // es and cs registers by port, read data stands one cycle only
    wr(`CMR_OFS_ES, 8'h03);
    wr(`CMR_OFS_CS, 8'h0a);
    chk({o_es, o_cs}, 8'h3a);
    rd(`CMR_OFS_ES, rv);
    chk(rv, 8'h03);
    @(posedge i_clock);
    #1;
    chk(o_reg_rdata, 8'h00);
    // second reset in mid-run, vector load is armed again
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    #1;
    chk(o_psw, `CMR_PSW_RST);
    chk({o_es, o_cs}, {`CMR_ES_RST, `CMR_CS_RST});
    chk(o_pc, 20'h00000);
    c = '0;
    c.vec_load = 1'b1;
    c.vec_data = ~rnd;
    cmdp(c);
    chk(o_pc, {4'h0, ~rnd});
    $display("test second reset done");
    close_out();
  end
endmodule : cmr_core_regs_tb
